/* common/fss_pkg.sv */
`default_nettype none

package fss_pkg;

   // ------------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] FSS_OFS_SEC_STATUS = 8'h00;
   localparam logic [7:0] FSS_OFS_PRI_STATUS = 8'h04;
   localparam logic [7:0] FSS_OFS_COMMAND = 8'h08;
   localparam logic [7:0] FSS_OFS_CRC_START = 8'h0c;
   localparam logic [7:0] FSS_OFS_CRC_END = 8'h10;
   localparam logic [7:0] FSS_OFS_EVAL_ADDR = 8'h14;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int FSS_BIT_RSVD_HI = 7;
   localparam int FSS_BIT_RSVD_LO = 5;
   localparam int FSS_BIT_CRC_SUSP = 4;
   localparam int FSS_BIT_CRC_ABORT = 3;
   localparam int FSS_BIT_SECTOR_ERASE_RESULT = 2;
   localparam int FSS_BIT_ERASE_SUSP = 1;
   localparam int FSS_BIT_PROG_SUSP = 0;
   localparam int FSS_BIT_BUSY = 0;
   localparam int FSS_CMD_CRC_START = 0;
   localparam int FSS_CMD_CRC_SUSPEND = 1;
   localparam int FSS_CMD_CRC_RESUME = 2;
   localparam int FSS_CMD_EVAL_ERASE = 3;

   // ------------------------------------------------------------------
   // Reset values and counts
   // ------------------------------------------------------------------
   localparam logic [7:0] FSS_SEC_STATUS_RST = 8'h00;
   localparam logic FSS_BUSY_RST = 1'b0;
   localparam logic FSS_SECTOR_OK_RST = 1'b0;
   localparam int FSS_CRC_MIN_SPAN = 3;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {FSS_CRC_IDLE, FSS_CRC_RUN, FSS_CRC_SUSP} fss_crc_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } fss_bus_req_t;

endpackage

`default_nettype wire

/* rtl/fss_status_flags.sv */
`timescale 1ns/1ps
`default_nettype none

module fss_status_flags
   import fss_pkg::*;
#(
   parameter int FLASH_AW = 25,
   parameter int SECTOR_AW = 18,
   parameter int SECTORS = 128
)
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire fss_bus_req_t bus_req_i,
   output logic [31:0] bus_rdata_o,
   input wire logic erase_suspended_i,
   input wire logic program_suspended_i,
   input wire logic erase_busy_i,
   input wire logic program_busy_i,
   input wire logic erase_done_i,
   input wire logic [$clog2(SECTORS)-1:0] erase_done_sector_i,
   input wire logic erase_ok_i,
   output logic ready_busy_flag_o,
   output logic crc_done_o,
   output logic [7:0] secondary_status_o
);

   localparam int SIDX_W = $clog2(SECTORS);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   fss_crc_state_t crc_state_reg;
   fss_crc_state_t crc_state_next;
   logic [FLASH_AW-1:0] crc_count_reg;
   logic [FLASH_AW-1:0] crc_count_next;
   logic [FLASH_AW-1:0] crc_start_address_reg;
   logic [FLASH_AW-1:0] crc_start_address_next;
   logic [FLASH_AW-1:0] crc_end_address_reg;
   logic [FLASH_AW-1:0] crc_end_address_next;
   logic [FLASH_AW-1:0] eval_addr_reg;
   logic [FLASH_AW-1:0] eval_addr_next;
   logic [7:0] secondary_status_reg;
   logic [7:0] secondary_status_next;
   logic ready_busy_flag_reg;
   logic ready_busy_flag_next;
   logic crc_done_reg;
   logic crc_done_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic sector_ok_reg [SECTORS];

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   logic cmd_wr;
   logic crc_start_cmd;
   logic crc_suspend_cmd;
   logic crc_resume_cmd;
   logic eval_cmd;
   logic [FLASH_AW:0] crc_limit;
   logic crc_range_bad;
   logic [SIDX_W-1:0] eval_idx;
   logic eval_bit;

   assign cmd_wr = bus_req_i.wr && (bus_req_i.addr == FSS_OFS_COMMAND);
   assign crc_start_cmd = cmd_wr && bus_req_i.wdata[FSS_CMD_CRC_START];
   assign crc_suspend_cmd = cmd_wr && bus_req_i.wdata[FSS_CMD_CRC_SUSPEND];
   assign crc_resume_cmd = cmd_wr && bus_req_i.wdata[FSS_CMD_CRC_RESUME];
   assign eval_cmd = cmd_wr && bus_req_i.wdata[FSS_CMD_EVAL_ERASE];
   assign crc_limit = {1'b0, crc_start_address_reg} + (FLASH_AW+1)'(FSS_CRC_MIN_SPAN);
   assign crc_range_bad = {1'b0, crc_end_address_reg} < crc_limit;
   assign eval_idx = eval_addr_reg[SECTOR_AW +: SIDX_W];
   assign eval_bit = (erase_done_i && (erase_done_sector_i == eval_idx)) ? erase_ok_i : sector_ok_reg[eval_idx];

   // ------------------------------------------------------------------
   // Address registers
   // ------------------------------------------------------------------
   always_comb
   begin
      crc_start_address_next = crc_start_address_reg;
      crc_end_address_next = crc_end_address_reg;
      eval_addr_next = eval_addr_reg;
      if (bus_req_i.wr && (bus_req_i.addr == FSS_OFS_CRC_START))
      begin
         crc_start_address_next = bus_req_i.wdata[FLASH_AW-1:0];
      end
      if (bus_req_i.wr && (bus_req_i.addr == FSS_OFS_CRC_END))
      begin
         crc_end_address_next = bus_req_i.wdata[FLASH_AW-1:0];
      end
      if (bus_req_i.wr && (bus_req_i.addr == FSS_OFS_EVAL_ADDR))
      begin
         eval_addr_next = bus_req_i.wdata[FLASH_AW-1:0];
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         crc_start_address_reg <= '0;
         crc_end_address_reg <= '0;
         eval_addr_reg <= '0;
      end
      else if (en_i)
      begin
         crc_start_address_reg <= crc_start_address_next;
         crc_end_address_reg <= crc_end_address_next;
         eval_addr_reg <= eval_addr_next;
      end
   end

   // ------------------------------------------------------------------
   // Per-sector erase result memory
   // ------------------------------------------------------------------
   for (genvar s = 0; s < SECTORS; s++)
   begin : g_sector
      logic ok_next;
      always_comb
      begin
         ok_next = sector_ok_reg[s];
         if (erase_done_i && (erase_done_sector_i == SIDX_W'(s)))
         begin
            ok_next = erase_ok_i;
         end
      end
      always_ff @(posedge sys_clk_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            sector_ok_reg[s] <= FSS_SECTOR_OK_RST;
         end
         else if (en_i)
         begin
            sector_ok_reg[s] <= ok_next;
         end
      end
   end

   // ------------------------------------------------------------------
   // CRC engine and status flags
   // ------------------------------------------------------------------
   always_comb
   begin
      crc_state_next = crc_state_reg;
      crc_count_next = crc_count_reg;
      crc_done_next = 1'b0;
      secondary_status_next = secondary_status_reg;
      unique case (crc_state_reg)
         FSS_CRC_IDLE:
         begin
            if (crc_start_cmd && !ready_busy_flag_reg)
            begin
               if (crc_range_bad)
               begin
                  secondary_status_next[FSS_BIT_CRC_ABORT] = 1'b1;
               end
               else
               begin
                  secondary_status_next[FSS_BIT_CRC_ABORT] = 1'b0;
                  crc_count_next = crc_end_address_reg - crc_start_address_reg;
                  crc_state_next = FSS_CRC_RUN;
               end
            end
         end
         FSS_CRC_RUN:
         begin
            if (crc_suspend_cmd)
            begin
               crc_state_next = FSS_CRC_SUSP;
            end
            else if (crc_count_reg == '0)
            begin
               crc_done_next = 1'b1;
               crc_state_next = FSS_CRC_IDLE;
            end
            else
            begin
               crc_count_next = crc_count_reg - FLASH_AW'(1);
            end
         end
         FSS_CRC_SUSP:
         begin
            if (crc_resume_cmd)
            begin
               crc_state_next = FSS_CRC_RUN;
            end
         end
      endcase
      if (eval_cmd && !ready_busy_flag_reg)
      begin
         secondary_status_next[FSS_BIT_SECTOR_ERASE_RESULT] = eval_bit;
      end
      secondary_status_next[FSS_BIT_RSVD_HI:FSS_BIT_RSVD_LO] = '0;
      secondary_status_next[FSS_BIT_CRC_SUSP] = (crc_state_next == FSS_CRC_SUSP);
      secondary_status_next[FSS_BIT_ERASE_SUSP] = erase_suspended_i;
      secondary_status_next[FSS_BIT_PROG_SUSP] = program_suspended_i;
      ready_busy_flag_next = (crc_state_next == FSS_CRC_RUN) || erase_busy_i || program_busy_i;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         crc_state_reg <= FSS_CRC_IDLE;
         crc_count_reg <= '0;
         crc_done_reg <= 1'b0;
         secondary_status_reg <= FSS_SEC_STATUS_RST;
         ready_busy_flag_reg <= FSS_BUSY_RST;
      end
      else if (en_i)
      begin
         // Same clock as the read port
         crc_state_reg <= crc_state_next;
         crc_count_reg <= crc_count_next;
         crc_done_reg <= crc_done_next;
         secondary_status_reg <= secondary_status_next;
         ready_busy_flag_reg <= ready_busy_flag_next;
      end
   end

   // ------------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------------
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      if (bus_req_i.rd)
      begin
         unique case (bus_req_i.addr)
            FSS_OFS_SEC_STATUS: rdata_next = {24'h00_0000, secondary_status_reg};
            FSS_OFS_PRI_STATUS: rdata_next = {31'h0000_0000, ready_busy_flag_reg};
            FSS_OFS_CRC_START: rdata_next = 32'(crc_start_address_reg);
            FSS_OFS_CRC_END: rdata_next = 32'(crc_end_address_reg);
            FSS_OFS_EVAL_ADDR: rdata_next = 32'(eval_addr_reg);
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_reg <= 32'h0000_0000;
      end
      else if (en_i)
      begin
         rdata_reg <= rdata_next;
      end
   end

   assign bus_rdata_o = rdata_reg;
   assign ready_busy_flag_o = ready_busy_flag_reg;
   assign crc_done_o = crc_done_reg;
   assign secondary_status_o = secondary_status_reg;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence seq_bad_start;
      en_i && crc_start_cmd && !ready_busy_flag_reg && (crc_state_reg == FSS_CRC_IDLE) && crc_range_bad;
   endsequence

   sequence seq_good_start;
      en_i && crc_start_cmd && !ready_busy_flag_reg && (crc_state_reg == FSS_CRC_IDLE) && !crc_range_bad;
   endsequence

   chk_reserved_zero: assert property (secondary_status_o[FSS_BIT_RSVD_HI:FSS_BIT_RSVD_LO] == 3'h0)
      else $error("reserved status bits not zero");

   chk_crc_susp_flag: assert property (secondary_status_o[FSS_BIT_CRC_SUSP] == (crc_state_reg == FSS_CRC_SUSP))
      else $error("crc suspend flag disagrees with engine state");

   chk_abort_set: assert property (seq_bad_start |=> secondary_status_o[FSS_BIT_CRC_ABORT] && !ready_busy_flag_o)
      else $error("invalid crc range did not abort");

   chk_abort_idle: assert property (seq_bad_start |=> (crc_state_reg == FSS_CRC_IDLE) && !crc_done_o)
      else $error("invalid crc range started a calculation");

   chk_abort_clear: assert property (seq_good_start |=> !secondary_status_o[FSS_BIT_CRC_ABORT] && ready_busy_flag_o)
      else $error("valid crc start did not clear abort");

   chk_susp_enter: assert property (en_i && crc_suspend_cmd && (crc_state_reg == FSS_CRC_RUN)
      |=> secondary_status_o[FSS_BIT_CRC_SUSP])
      else $error("crc suspend did not raise suspend flag");

   chk_eval_result: assert property (en_i && eval_cmd && !ready_busy_flag_reg
      |=> secondary_status_o[FSS_BIT_SECTOR_ERASE_RESULT] == $past(eval_bit))
      else $error("erase result flag wrong after evaluate");

   chk_erase_susp: assert property (en_i |=> secondary_status_o[FSS_BIT_ERASE_SUSP] == $past(erase_suspended_i))
      else $error("erase suspend flag does not follow");

   chk_prog_susp: assert property (en_i |=> secondary_status_o[FSS_BIT_PROG_SUSP] == $past(program_suspended_i))
      else $error("program suspend flag does not follow");

   chk_busy_flag: assert property (en_i && (erase_busy_i || program_busy_i) |=> ready_busy_flag_o)
      else $error("busy flag low during embedded operation");

   chk_read_byte: assert property (en_i && bus_req_i.rd && (bus_req_i.addr == FSS_OFS_SEC_STATUS)
      |=> bus_rdata_o == {24'h00_0000, $past(secondary_status_reg)})
      else $error("status read returned wrong byte");

endmodule // fss_status_flags

`default_nettype wire

/* testbench/fss_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Erase and program engine stand-in
// ------------------------------------------------------------------
module fss_engine_model
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [1:0] susp_i,
   input wire logic [1:0] busy_i,
   input wire logic done_i,
   input wire logic [6:0] sector_i,
   input wire logic ok_i,
   output logic erase_suspended_o,
   output logic program_suspended_o,
   output logic erase_busy_o,
   output logic program_busy_o,
   output logic erase_done_o,
   output logic [6:0] erase_done_sector_o,
   output logic erase_ok_o
);
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         {erase_suspended_o, program_suspended_o, erase_busy_o, program_busy_o} <= 4'h0;
         erase_done_o <= 1'b0;
         erase_done_sector_o <= 7'h00;
         erase_ok_o <= 1'b0;
      end
      else
      begin
         {erase_suspended_o, program_suspended_o} <= susp_i;
         {erase_busy_o, program_busy_o} <= busy_i;
         erase_done_o <= done_i;
         // Qualifiers turn to junk outside the pulse
         erase_done_sector_o <= done_i ? sector_i : ~erase_done_sector_o;
         erase_ok_o <= done_i ? ok_i : ~erase_ok_o;
      end
   end
endmodule // fss_engine_model

`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top import fss_pkg::*;;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1;
   fss_bus_req_t req = '0;
   logic [31:0] rdata;
   logic [1:0] susp = 2'h0;
   logic [1:0] busy = 2'h0;
   logic done = 1'b0;
   logic ok = 1'b0;
   logic [6:0] sector = 7'h00;
   logic es, ps, eb, pb, ed, eok, rbf, crc_done;
   logic [6:0] esec;
   logic [7:0] sec_stat;
   int n_fail = 0;
   int checks_done = 0;
   int n_done = 0;
   int cyc = 0;

   always #50 clk = ~clk;

   fss_engine_model eng_u (.sys_clk_i(clk), .rst_i(rst), .susp_i(susp), .busy_i(busy), .done_i(done),
      .sector_i(sector), .ok_i(ok), .erase_suspended_o(es), .program_suspended_o(ps), .erase_busy_o(eb),
      .program_busy_o(pb), .erase_done_o(ed), .erase_done_sector_o(esec), .erase_ok_o(eok));

   fss_status_flags dut_u (.sys_clk_i(clk), .rst_i(rst), .en_i(en), .bus_req_i(req), .bus_rdata_o(rdata),
      .erase_suspended_i(es), .program_suspended_i(ps), .erase_busy_i(eb), .program_busy_i(pb),
      .erase_done_i(ed), .erase_done_sector_i(esec), .erase_ok_i(eok), .ready_busy_flag_o(rbf),
      .crc_done_o(crc_done), .secondary_status_o(sec_stat));

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic stop_test();
      if (n_fail == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         n_fail++;
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req <= '0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk);
      req <= '0;
      #1;
      chk("read data", exp, rdata);
   endtask

   task automatic crc(input logic [31:0] s, input logic [31:0] e);
      bus_wr(FSS_OFS_CRC_START, s);
      bus_wr(FSS_OFS_CRC_END, e);
      bus_wr(FSS_OFS_COMMAND, 32'h1);
      #1;
   endtask

   task automatic wait_done();
      int i;
      i = 0;
      while (crc_done !== 1'b1 && i < 200)
      begin
         @(posedge clk);
         #1;
         i++;
      end
      if (crc_done !== 1'b1)
      begin
         n_fail++;
         stop_test();
      end
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic sc_readonly();
      rd_chk(FSS_OFS_SEC_STATUS, 32'h0);
      bus_wr(FSS_OFS_SEC_STATUS, 32'h0000_001f);
      rd_chk(FSS_OFS_SEC_STATUS, 32'h0);
      chk("status port", 32'h0, {24'h0, sec_stat});
   endtask

   task automatic sc_crc();
      int c;
      c = n_done;
      crc(32'h100, 32'h102);
      chk("busy", 32'h0, {31'h0, rbf});
      rd_chk(FSS_OFS_SEC_STATUS, 32'h08);
      rd_chk(FSS_OFS_CRC_END, 32'h102);
      rd_chk(FSS_OFS_PRI_STATUS, 32'h0);
      chk("done count", c, n_done);
      crc(32'h100, 32'h103);
      chk("busy", 32'h1, {31'h0, rbf});
      wait_done();
      chk("busy", 32'h0, {31'h0, rbf});
      rd_chk(FSS_OFS_SEC_STATUS, 32'h0);
      chk("done count", c + 1, n_done);
      crc(32'h0, 32'h40);
      bus_wr(FSS_OFS_COMMAND, 32'h2);
      rd_chk(FSS_OFS_PRI_STATUS, 32'h0);
      rd_chk(FSS_OFS_SEC_STATUS, 32'h10);
      bus_wr(FSS_OFS_COMMAND, 32'h4);
      rd_chk(FSS_OFS_PRI_STATUS, 32'h1);
      wait_done();
      rd_chk(FSS_OFS_PRI_STATUS, 32'h0);
      rd_chk(FSS_OFS_SEC_STATUS, 32'h0);
   endtask

   task automatic sc_eval();
      logic [6:0] secs [5];
      logic [4:0] exp;
      secs = '{7'h05, 7'h09, 7'h05, 7'h03, 7'h09};
      exp = 5'b00101;
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk);
         done <= 1'b1;
         sector <= secs[k];
         ok <= (k == 0);
         @(posedge clk);
         done <= 1'b0;
      end
      for (int k = 0; k < 5; k++)
      begin
         bus_wr(FSS_OFS_EVAL_ADDR, {7'h0, secs[k], 18'h0});
         bus_wr(FSS_OFS_COMMAND, 32'h8);
         rd_chk(FSS_OFS_SEC_STATUS, {29'h0, exp[k], 2'h0});
      end
   endtask

   task automatic sc_engine();
      for (int v = 0; v < 4; v++)
      begin
         @(posedge clk);
         susp <= v[1:0];
         repeat (2) @(posedge clk);
         rd_chk(FSS_OFS_SEC_STATUS, v);
         chk("status port", v, {24'h0, sec_stat});
      end
      @(posedge clk);
      en <= 1'b0;
      susp <= 2'h0;
      repeat (3) @(posedge clk);
      #1;
      chk("frozen status", 32'h3, {24'h0, sec_stat});
      @(posedge clk);
      en <= 1'b1;
      for (int b = 1; b < 4; b++)
      begin
         @(posedge clk);
         busy <= b[1:0];
         repeat (2) @(posedge clk);
         rd_chk(FSS_OFS_PRI_STATUS, 32'h1);
      end
      @(posedge clk);
      busy <= 2'h0;
      repeat (2) @(posedge clk);
      rd_chk(FSS_OFS_PRI_STATUS, 32'h0);
   endtask

   task automatic sc_reset();
      crc(32'h200, 32'h201);
      rd_chk(FSS_OFS_SEC_STATUS, 32'h08);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk(FSS_OFS_SEC_STATUS, 32'h0);
      rd_chk(FSS_OFS_CRC_START, 32'h0);
   endtask

   // ------------------------------------------------------------------
   // Main sequence and hang guard
   // ------------------------------------------------------------------
   always @(posedge clk)
   begin
      if (crc_done === 1'b1)
         n_done++;
      cyc++;
      if (cyc > 20000)
      begin
         n_fail++;
         stop_test();
      end
   end

   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      sc_readonly();
      sc_crc();
      sc_eval();
      sc_engine();
      sc_reset();
      stop_test();
   end
endmodule // tb_top

`default_nettype wire
